//--- adcrd_ctrl.sv
// Host-side controller driving the converter's select and read pins and sampling its data pins
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_defs.svh"

// How it works
// [RULE_01] Both selects low: read-not-write low converts, high reads.
// [RULE_02] All three low 300 ns raises the busy status.
// [RULE_03] Device ignores new starts while converting.
// [RULE_04] Device keeps its data buffer off during a conversion.
// [RULE_05] Data pins float except during a read cycle.
// [RULE_06] Host starts a read with read-not-write high and selects low.
// [RULE_07] Data valid within 250 ns; host waits that long before sampling.
// [RULE_08] Host ends a read by raising the selects.
// [RULE_09] Data held 25 ns after deselect, floats within 150 ns.
// [RULE_10] Stand-alone: selects driven together, control via read-not-write.
// [RULE_11] Stand-alone conversion begins within 700 ns of the low edge.
// [RULE_12] Single mode: raise read-not-write once the conversion starts.
// [RULE_13] Stand-alone result stays driven until deselect or new low.
// [RULE_14] Held low, conversions run back to back with status pulses.
// [RULE_15] Raising read-not-write gives one final conversion and its data.
// [RULE_16] Raise read-not-write only while status is high.
// [RULE_17] Continuous: hold read-not-write low at least 10.25 us.
// [RULE_18] Final result becomes valid; a new low starts a new series.
// [RULE_19] Status falls and the result is latched at conversion end.
module adcrd_ctrl (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       req,
    input  wire logic [1:0] mode,
    input  wire logic       read_only,
    output logic            busy,
    output logic            done,
    output logic            timeout,
    output logic [7:0]      result,
    output logic            chip_enable_n,
    output logic            chip_select_n,
    output logic            read_not_write,
    input  wire logic       conv_status,
    input  wire logic [7:0] data_in
);
    typedef struct packed {
        adcrd_pkg::adcrd_state_e st;
        adcrd_pkg::adcrd_mode_e  md;
        logic                    rd_only;
        adcrd_pkg::adcrd_cnt_t   cnt;
        logic [13:0]             wd;
        logic                    ce_n;
        logic                    cs_n;
        logic                    rnw;
        logic                    done;
        logic                    tout;
        adcrd_pkg::adcrd_byte_t  res;
    } adcrd_ctrl_s;

    adcrd_ctrl_s r_q;
    adcrd_ctrl_s r_d;
    logic        status;

    // Status comes from the converter pin, another time domain
    adcrd_sync u_status_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (conv_status),
        .level (status)
    );

    // Sequencer; the watchdog guards against a converter that never answers
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        r_d.wd = r_q.wd + 14'h0001;
        if (r_q.cnt != '0) begin
            r_d.cnt = r_q.cnt - 11'h001;
        end
        case (r_q.st)
            adcrd_pkg::ST_IDLE: begin
                r_d.wd = '0;
                if (req) begin
                    r_d.md = adcrd_pkg::adcrd_mode_e'(mode);
                    r_d.rd_only = read_only && (mode == 2'h0);
                    r_d.tout = 1'b0;
                    r_d.ce_n = 1'b0; // [RULE_01] [RULE_10]
                    r_d.cs_n = 1'b0;
                    if (read_only && (mode == 2'h0)) begin
                        r_d.rnw = 1'b1; // [RULE_06]
                        r_d.cnt = 11'(`ADCRD_BUS_ACCESS_CYC + 2);
                        r_d.st = adcrd_pkg::ST_ACCESS;
                    end else begin
                        r_d.rnw = 1'b0; // [RULE_01]
                        r_d.cnt = (mode == 2'h2) ?
                            11'(`ADCRD_CONT_LOW_CYC) :
                            11'(`ADCRD_START_PULSE_CYC); // [RULE_02] [RULE_17]
                        r_d.st = adcrd_pkg::ST_START;
                    end
                end
            end
            adcrd_pkg::ST_START: begin
                // Low pulse held out; then watch for status
                if (r_q.cnt == '0) begin
                    r_d.st = adcrd_pkg::ST_WAIT_BUSY;
                end
            end
            adcrd_pkg::ST_WAIT_BUSY: begin
                if (status) begin
                    r_d.st = adcrd_pkg::ST_RISE; // [RULE_11] [RULE_14]
                end
            end
            adcrd_pkg::ST_RISE: begin
                if (!status) begin
                    // Busy fell before we rose: wait for the next one
                    r_d.st = adcrd_pkg::ST_WAIT_BUSY; // [RULE_16]
                end else begin
                    r_d.rnw = 1'b1; // [RULE_12] [RULE_15] [RULE_16]
                    if (r_q.md == adcrd_pkg::MODE_BUS) begin
                        r_d.ce_n = 1'b1;
                        r_d.cs_n = 1'b1;
                    end
                    r_d.st = adcrd_pkg::ST_WAIT_DONE; // [RULE_03]
                end
            end
            adcrd_pkg::ST_WAIT_DONE: begin
                if (!status) begin // [RULE_19]
                    r_d.ce_n = 1'b0;
                    r_d.cs_n = 1'b0;
                    r_d.cnt = 11'(`ADCRD_BUS_ACCESS_CYC + 2); // [RULE_04]
                    r_d.st = adcrd_pkg::ST_ACCESS;
                end
            end
            adcrd_pkg::ST_ACCESS: begin
                // Allow for access time plus our sync latency
                if (r_q.cnt == '0) begin
                    r_d.res = data_in; // [RULE_07] [RULE_13] [RULE_18]
                    r_d.st = adcrd_pkg::ST_DESELECT;
                end
            end
            adcrd_pkg::ST_DESELECT: begin
                r_d.ce_n = 1'b1; // [RULE_08]
                r_d.cs_n = 1'b1;
                r_d.cnt = 11'(`ADCRD_FLOAT_CYC);
                r_d.st = adcrd_pkg::ST_FLOAT;
            end
            adcrd_pkg::ST_FLOAT: begin
                // Bus turnaround before a new request may drive it
                if (r_q.cnt == '0) begin
                    r_d.done = 1'b1; // [RULE_09] [RULE_05]
                    r_d.st = adcrd_pkg::ST_IDLE;
                end
            end
            default: begin
                r_d.st = adcrd_pkg::ST_IDLE;
            end
        endcase
        if ((r_q.st != adcrd_pkg::ST_IDLE) &&
            (r_q.wd == 14'(`ADCRD_TIMEOUT_CYC * 2))) begin
            r_d.tout = 1'b1;
            r_d.ce_n = 1'b1;
            r_d.cs_n = 1'b1;
            r_d.rnw = 1'b1;
            r_d.done = 1'b1;
            r_d.st = adcrd_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '{st: adcrd_pkg::ST_IDLE, md: adcrd_pkg::MODE_BUS,
                     rd_only: 1'b0, cnt: '0, wd: '0, ce_n: 1'b1,
                     cs_n: 1'b1, rnw: 1'b1, done: 1'b0, tout: 1'b0,
                     res: 8'h00};
        end else begin
            r_q <= r_d;
        end
    end

    // Pin and user-side outputs straight from flip-flops, except busy, which is decoded from the state
    assign chip_enable_n  = r_q.ce_n;
    assign chip_select_n  = r_q.cs_n;
    assign read_not_write = r_q.rnw;
    assign result         = r_q.res;
    assign done           = r_q.done;
    assign timeout        = r_q.tout;
    assign busy           = (r_q.st != adcrd_pkg::ST_IDLE);
endmodule
`default_nettype wire

//--- adcrd_ctrl_properties.sv
// Port checks for the converter bus controller
`timescale 1ns/1ps
`default_nettype none
module adcrd_ctrl_properties (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] mode,
    input wire logic       busy,
    input wire logic       done,
    input wire logic [7:0] result,
    input wire logic       chip_enable_n,
    input wire logic       chip_select_n,
    input wire logic       read_not_write,
    input wire logic       conv_status
);
    logic [10:0] low_q;
    logic [10:0] rd_q;
    // Saturating phase counters, so long conversions never wrap
    always_ff @(posedge clk) begin
        low_q <= (chip_select_n | read_not_write) ? 11'h000
               : low_q + 11'(~&low_q);
        rd_q  <= (chip_select_n | ~read_not_write) ? 11'h000
               : rd_q + 11'(~&rd_q);
    end
    // Steps after a status rise and after a read ends
    sequence s_rnw_up;
        ##[1:8] $rose(read_not_write);
    endsequence
    sequence s_float_done;
        (chip_select_n && !done) [*8] ##[1:12] done;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_sel_tied: assert property (chip_enable_n == chip_select_n)
        else $error("selects differ");
    chk_sel_busy: assert property (!chip_select_n |-> busy)
        else $error("selects low while idle");
    chk_rise_status: assert property (
        $rose(read_not_write) |-> conv_status)
        else $error("rnw rose with status low");
    chk_start_hold: assert property (
        $rose(read_not_write) |-> low_q >= 11'h01E)
        else $error("convert pulse too short");
    chk_cont_hold: assert property ($rose(read_not_write) && mode == 2'h2
        |-> low_q >= 11'h401)
        else $error("continuous low too short");
    chk_read_access: assert property ($rose(chip_select_n)
        && $past(read_not_write) |-> rd_q >= 11'h019)
        else $error("read ended before access time");
    chk_read_float: assert property ($rose(chip_select_n)
        && $past(read_not_write) |-> s_float_done)
        else $error("done not after float delay");
    chk_result_src: assert property ($changed(result) && $past(rst_n)
        |-> !$past(chip_select_n) && $past(read_not_write))
        else $error("result changed outside read");
    chk_single_rise: assert property ($rose(conv_status) && mode == 2'h1
        |-> s_rnw_up)
        else $error("rnw not raised after start");
endmodule
bind adcrd_ctrl adcrd_ctrl_properties adcrd_ctrl_properties_i (.clk, .rst_n,
    .mode, .busy, .done, .result, .chip_enable_n, .chip_select_n,
    .read_not_write, .conv_status);
`default_nettype wire

//--- adcrd_ctrl_tb_top.sv
// Self-checking bench for the converter bus controller
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin \
    n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module adcrd_ctrl_tb_top;
    logic       clk, rst_n, req, read_only, busy, done, timeout;
    logic       chip_enable_n, chip_select_n, read_not_write, conv_status;
    logic [1:0] mode;
    logic [7:0] result, data_in, conv_value;
    int         n_mismatch, n_compared, n_conv, k, w, c0, exp_val;
    logic [2:0] plan [6] = '{3'h1, 3'h0, 3'h1, 3'h2, 3'h4, 3'h2};
    adcrd_ctrl adcrd_ctrl_i (.clk, .rst_n, .req, .mode, .read_only, .busy,
        .done, .timeout, .result, .chip_enable_n, .chip_select_n,
        .read_not_write, .conv_status, .data_in);
    adcrd_dev_model adcrd_dev_model_i (.clk, .chip_enable_n, .chip_select_n,
        .read_not_write, .conv_value, .conv_status, .data_out(data_in),
        .n_conv);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Request held three cycles: repeats while busy must be ignored
    task automatic run(input logic [2:0] p);
        c0 = n_conv;
        mode <= p[2:1];
        read_only <= p[0];
        conv_value <= 8'($urandom);
        req <= 1'b1;
        repeat (3) @(posedge clk);
        req <= 1'b0;
        for (w = 0; w < 3000 && done !== 1'b1; w++) @(posedge clk);
        if (w == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
        if (!p[0]) exp_val = conv_value;
        `CHECK("result", 8'(exp_val), result)
        `CHECK("timeout", 1'b0, timeout)
        `CHECK("conversions", p[0] ? 0 : 1, n_conv - c0)
        repeat (2) @(posedge clk);
        `CHECK("idle", 1'b0, busy)
        `CHECK("rnw idle", 1'b1, read_not_write)
    endtask
    // Reset, then every mode with random converted values
    initial begin
        {rst_n, req, read_only, mode, conv_value} = '0;
        {n_mismatch, n_compared, exp_val} = '0;
        k = $urandom(69);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHECK("select reset", 1'b1, chip_select_n)
        for (k = 0; k < 6; k++) run(plan[k]);
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- adcrd_defs.svh
// Timing constants for the converter bus controller
`ifndef ADCRD_DEFS_SVH
`define ADCRD_DEFS_SVH
`define ADCRD_CLK_PERIOD_NS      10
// Round up so no pin delay is ever cut short
`define ADCRD_NS_TO_CYC(ns) \
    (((ns) + `ADCRD_CLK_PERIOD_NS - 1) / `ADCRD_CLK_PERIOD_NS)
`define ADCRD_START_PULSE_NS     300
`define ADCRD_START_PULSE_CYC    `ADCRD_NS_TO_CYC(`ADCRD_START_PULSE_NS)
`define ADCRD_CONV_DELAY_NS      700
`define ADCRD_CONV_DELAY_CYC     `ADCRD_NS_TO_CYC(`ADCRD_CONV_DELAY_NS)
`define ADCRD_BUS_ACCESS_NS      250
`define ADCRD_BUS_ACCESS_CYC     `ADCRD_NS_TO_CYC(`ADCRD_BUS_ACCESS_NS)
`define ADCRD_FLOAT_NS           150
`define ADCRD_FLOAT_CYC          `ADCRD_NS_TO_CYC(`ADCRD_FLOAT_NS)
`define ADCRD_CONT_LOW_NS        10250
`define ADCRD_CONT_LOW_CYC       `ADCRD_NS_TO_CYC(`ADCRD_CONT_LOW_NS)
`define ADCRD_CONV_TIME_NS       10000
`define ADCRD_CONV_TIME_CYC      `ADCRD_NS_TO_CYC(`ADCRD_CONV_TIME_NS)
`define ADCRD_TIMEOUT_CYC \
    (`ADCRD_CONV_TIME_CYC + `ADCRD_CONV_DELAY_CYC + `ADCRD_BUS_ACCESS_CYC)
`endif

//--- adcrd_dev_model.sv
// Behavioural converter seen from its bus pins
`timescale 1ns/1ps
`default_nettype none
module adcrd_dev_model #(parameter int CONV_CYC = 1000) (
    input  wire logic       clk,
    input  wire logic       chip_enable_n,
    input  wire logic       chip_select_n,
    input  wire logic       read_not_write,
    input  wire logic [7:0] conv_value,
    output logic            conv_status,
    output logic [7:0]      data_out,
    output int              n_conv
);
    int         low_c, conv_c, rd_c, hold_c;
    logic [7:0] latch_q;
    logic       sel;
    assign sel = !chip_enable_n && !chip_select_n;
    // One process, so every output has a single driver
    initial begin
        {conv_status, latch_q, data_out} = {1'b0, 8'h00, 8'h5A};
        {n_conv, low_c, conv_c, rd_c} = '0;
        hold_c = 3;
        forever begin
            @(posedge clk);
            low_c = (sel && !read_not_write && !conv_status) ?
                low_c + 1 : 0;
            rd_c = (sel && read_not_write && !conv_status) ?
                rd_c + 1 : 0;
            hold_c = (rd_c >= 20) ? 0 : hold_c + 1;
            // Released pins toggle so a stale sample cannot match
            data_out <= (hold_c < 3) ?
                latch_q : ~data_out;
            if (conv_status && ++conv_c == CONV_CYC)
                {conv_status, latch_q} <= {1'b0, conv_value};
            else if (low_c == 30) begin
                conv_status <= 1'b1;
                conv_c = 0;
                n_conv++;
            end
        end
    end
endmodule
`default_nettype wire

//--- adcrd_pkg.sv
// Types for the converter bus controller
`default_nettype none
package adcrd_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_WAIT_BUSY, ST_RISE, ST_WAIT_DONE,
        ST_ACCESS, ST_DESELECT, ST_FLOAT
    } adcrd_state_e;
    typedef enum logic [1:0] {
        MODE_BUS, MODE_SINGLE, MODE_CONT
    } adcrd_mode_e;
    typedef logic [7:0]  adcrd_byte_t;
    typedef logic [10:0] adcrd_cnt_t;
    typedef struct packed {
        logic q1;
        logic q2;
        logic q3;
        logic val;
    } adcrd_sync_s;
endpackage
`default_nettype wire

//--- adcrd_sync.sv
// Three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module adcrd_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);
    adcrd_pkg::adcrd_sync_s s_q;
    adcrd_pkg::adcrd_sync_s s_d;

    // Stage one feeds only stage two
    always_comb begin
        s_d = s_q;
        s_d.q1 = pin;
        s_d.q2 = s_q.q1;
        s_d.q3 = s_q.q2;
        if (s_q.q2 == s_q.q3) begin
            s_d.val = s_q.q3;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.val;
endmodule
`default_nettype wire
